//--- src/bctl_pkg.sv
package bctl_pkg;

  // register map, word address on the control bus
  localparam logic [9:0]  BOARD_CONTROL_ADDR = 10'h009;

  // big-endian bit numbering: printed bit n is data bit (31 - n)
  localparam int          ERR_CLEAR_BIT      = 31;
  localparam int          LAMP_BIT           = 28;
  localparam int          SHUTDOWN_MSB       = 11;
  localparam int          SHUTDOWN_LSB       = 0;

  // reset values and the power-down code
  localparam logic [11:0] SHUTDOWN_RESET     = 12'h000;
  localparam logic [11:0] SHUTDOWN_CODE      = 12'h0ff;
  localparam logic        LAMP_RESET         = 1'b0;

  // bus answer latency, in cycles
  localparam int          ACK_DELAY_CYCLES   = 1;

  // control bus request
  typedef struct packed {
    logic        read;
    logic        write;
    logic [9:0]  addr;
    logic [31:0] wdata;
  } bctl_req_type;

  // board-side control outputs
  typedef struct packed {
    logic        err_clear;
    logic        lamp_on;
    logic        shutdown_req;
    logic [11:0] shutdown_code;
  } bctl_ctl_type;

  typedef enum logic [1:0] {
    BCTL_LAMP_WAIT = 2'b01,
    BCTL_LAMP_RUN  = 2'b10
  } bctl_lamp_state_type;

endpackage

//--- src/bctl_sync.sv
`timescale 1ns/1ps
// three-stage synchroniser; output changes once stages two and three agree
module bctl_sync (
  // clock and reset
  input  wire logic sys_clk,
  input  wire logic reset_n,
  input  wire logic clk_en,
  // level
  input  wire logic async_in,
  output logic      sync_out
);

  logic [2:0] stage;
  logic       agree;

  assign agree = (stage[1] == stage[2]);

  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      stage <= 3'h0;
    end else if (clk_en) begin
      stage <= {stage[1:0], async_in};
    end
  end

  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      sync_out <= 1'b0;
    end else if (clk_en && agree) begin
      sync_out <= stage[2];
    end
  end

endmodule

//--- src/bctl_board_control.sv
`timescale 1ns/1ps
// Contract
// - writing one to printed bit 0 clears the latched bus-error lamp.
// - lamps switch on automatically after reset once all clock managers lock.
// - after reset, writes to printed bit 3 set lamps off or on.
// - shutdown field holding 0x0FF requests board power-down.
// - shutdown field resets to all zeros.
// - bus master clock and block clock synchronous, integer frequency ratio.
module bctl_board_control (
  // clock and reset
  input  wire logic                  sys_clk,
  input  wire logic                  reset_n,
  input  wire logic                  clk_en,
  // control bus slave
  input  wire bctl_pkg::bctl_req_type bus_req,
  output logic                       bus_ack,
  output logic [31:0]                bus_rdata,
  // board status
  input  wire logic                  clk_locked,
  input  wire logic                  bus_error,
  // board controls
  output logic                       error_lamp,
  output bctl_pkg::bctl_ctl_type     board_ctl
);

  bctl_pkg::bctl_lamp_state_type lamp_state;
  bctl_pkg::bctl_lamp_state_type next_lamp_state;

  // board pins: bit 0 is clock lock, bit 1 is bus error
  logic [1:0]             pin_in;
  logic [1:0]             pin_sync;
  logic                   locked_sync;
  logic                   error_sync;

  // bus decode and answer
  logic                   hit;
  logic                   access;
  logic                   wr_hit;
  logic                   rd_hit;
  logic                   req_d;
  logic                   next_req_d;

  // write data split into its fields
  logic                   wr_clear_bit;
  logic                   wr_lamp_bit;
  logic [11:0]            wr_code;

  // register fields and their next values
  logic                   err_clear;
  logic                   next_err_clear;
  logic                   lamp_on;
  logic                   next_lamp_on;
  logic                   lamp_auto;
  logic [11:0]            shutdown_code;
  logic [11:0]            next_shutdown_code;
  logic                   error_latched;
  logic                   next_error;
  logic [31:0]            next_rdata;
  bctl_pkg::bctl_ctl_type next_board_ctl;

  // address decode, kept in one place for every strobe
  function automatic logic addr_match(input logic [9:0] addr);
    addr_match = (addr == bctl_pkg::BOARD_CONTROL_ADDR);
  endfunction

  // a request stands while either strobe is up
  function automatic logic req_pending(input bctl_pkg::bctl_req_type req);
    req_pending = req.read | req.write;
  endfunction

  // the one field value that asks for power-down
  function automatic logic code_is_shutdown(input logic [11:0] code);
    code_is_shutdown = (code == bctl_pkg::SHUTDOWN_CODE);
  endfunction

  assign pin_in = {bus_error, clk_locked};

  // both pins cross the same way
  // a pulse shorter than two cycles can be lost
  for (genvar idx = 0; idx < 2; idx++) begin : g_pin_sync
    bctl_sync u_sync (
      .sys_clk  (sys_clk),
      .reset_n  (reset_n),
      .clk_en   (clk_en),
      .async_in (pin_in[idx]),
      .sync_out (pin_sync[idx])
    );
  end

  assign locked_sync = pin_sync[0];
  assign error_sync  = pin_sync[1];

  // requests run on sys_clk, no crossing
  assign hit        = addr_match(bus_req.addr);
  assign access     = hit && req_pending(bus_req);
  assign wr_hit     = access && bus_req.write && !req_d;
  assign rd_hit     = access && bus_req.read && !req_d;
  assign next_req_d = access;

  // ack one cycle after the take, held while the request stands
  assign bus_ack = req_d && access;

  // printed bit n sits on data bit 31 - n
  assign wr_clear_bit = bus_req.wdata[bctl_pkg::ERR_CLEAR_BIT];
  assign wr_lamp_bit  = bus_req.wdata[bctl_pkg::LAMP_BIT];
  assign wr_code      = bus_req.wdata[bctl_pkg::SHUTDOWN_MSB:bctl_pkg::SHUTDOWN_LSB];

  assign next_err_clear = wr_hit ? wr_clear_bit : err_clear;

  // held clear beats a new error, lamp stays dark until re-armed
  assign next_error = err_clear ? 1'b0 : (error_latched | error_sync);

  assign lamp_auto = (lamp_state == bctl_pkg::BCTL_LAMP_WAIT) && locked_sync;

  assign next_lamp_on = wr_hit ? wr_lamp_bit : (lamp_on | lamp_auto);

  assign next_shutdown_code = wr_hit ? wr_code : shutdown_code;

  // all fields write-only, reads give zero
  assign next_rdata = 32'h0000_0000;

  assign next_board_ctl = {err_clear, lamp_on, code_is_shutdown(shutdown_code), shutdown_code};

  always_comb begin
    next_lamp_state = lamp_state;
    case (lamp_state)
      bctl_pkg::BCTL_LAMP_WAIT: begin
        if (locked_sync) begin
          next_lamp_state = bctl_pkg::BCTL_LAMP_RUN;
        end
      end
      bctl_pkg::BCTL_LAMP_RUN: begin
        next_lamp_state = bctl_pkg::BCTL_LAMP_RUN;
      end
      default: begin
        next_lamp_state = bctl_pkg::BCTL_LAMP_WAIT;
      end
    endcase
  end

  // state only moves with the enable
  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      lamp_state <= bctl_pkg::BCTL_LAMP_WAIT;
    end else if (clk_en) begin
      lamp_state <= next_lamp_state;
    end
  end

  // blocks a second take of one request
  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      req_d <= 1'b0;
    end else if (clk_en) begin
      req_d <= next_req_d;
    end
  end

  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      err_clear <= 1'b0;
    end else if (clk_en) begin
      err_clear <= next_err_clear;
    end
  end

  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      shutdown_code <= bctl_pkg::SHUTDOWN_RESET;
    end else if (clk_en) begin
      shutdown_code <= next_shutdown_code;
    end
  end

  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      lamp_on <= bctl_pkg::LAMP_RESET;
    end else if (clk_en) begin
      lamp_on <= next_lamp_on;
    end
  end

  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      error_latched <= 1'b0;
    end else if (clk_en) begin
      error_latched <= next_error;
    end
  end

  // read data loads at a read take
  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      bus_rdata <= 32'h0000_0000;
    end else if (clk_en && rd_hit) begin
      bus_rdata <= next_rdata;
    end
  end

  assign error_lamp = error_latched;

  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      board_ctl <= '0;
    end else if (clk_en) begin
      board_ctl <= next_board_ctl;
    end
  end

endmodule

//--- testbench/bctl_board_control_monitor.sv
`timescale 1ns/1ps
module bctl_board_control_monitor (
  // clock and reset
  input wire logic                   sys_clk,
  input wire logic                   reset_n,
  input wire logic                   clk_en,
  // bus and board
  input wire bctl_pkg::bctl_req_type bus_req,
  input wire logic                   bus_ack,
  input wire logic [31:0]            bus_rdata,
  input wire logic                   clk_locked,
  input wire logic                   bus_error,
  input wire logic                   error_lamp,
  input wire bctl_pkg::bctl_ctl_type board_ctl
);
  default clocking @(posedge sys_clk); endclocking
  default disable iff (!reset_n);
  wire take  = clk_en && bus_req.addr == 10'h009 && (bus_req.read || bus_req.write) && !bus_ack;
  wire wtake = take && bus_req.write;
  property p_clear; wtake && bus_req.wdata[31] |-> ##2 board_ctl.err_clear && !error_lamp; endproperty
  a_clear: assert property (p_clear) else $error("error lamp not cleared");
  property p_auto; $rose(clk_locked) |-> ##[1:8] board_ctl.lamp_on; endproperty
  a_auto: assert property (p_auto) else $error("lamp not auto on");
  property p_lamp; wtake |-> ##2 board_ctl.lamp_on == $past(bus_req.wdata[28], 2); endproperty
  a_lamp: assert property (p_lamp) else $error("lamp not written");
  property p_code; wtake |-> ##2 board_ctl.shutdown_code == $past(bus_req.wdata[11:0], 2); endproperty
  a_code: assert property (p_code) else $error("code not written");
  property p_req; board_ctl.shutdown_req == (board_ctl.shutdown_code == 12'h0ff); endproperty
  a_req: assert property (p_req) else $error("bad shutdown request");
  property p_rst; $rose(reset_n) |-> board_ctl.shutdown_code == 12'h000; endproperty
  a_rst: assert property (p_rst) else $error("code not cleared");
  property p_ack; take |=> bus_ack; endproperty
  a_ack: assert property (p_ack) else $error("no ack");
  property p_rd; bus_ack && bus_req.read |-> bus_rdata == 32'h0; endproperty
  a_rd: assert property (p_rd) else $error("read not zero");
  c_wr: cover property (wtake);
  c_rd: cover property (take && bus_req.read);
  c_err: cover property (error_lamp);
  c_off: cover property (board_ctl.shutdown_req);
endmodule
bind bctl_board_control bctl_board_control_monitor mon (.sys_clk, .reset_n, .clk_en, .bus_req,
  .bus_ack, .bus_rdata, .clk_locked, .bus_error, .error_lamp, .board_ctl);

//--- testbench/bctl_master.sv
`timescale 1ns/1ps
module bctl_master (
  // clock
  input wire logic               sys_clk,
  // bus
  input wire logic               bus_ack,
  input wire logic [31:0]        bus_rdata,
  output bctl_pkg::bctl_req_type bus_req
);
  initial bus_req = '0;
  task automatic xfer(input logic rd, input logic [9:0] a, input logic [31:0] d,
                      output logic [31:0] q);
    int n;
    @(negedge sys_clk);
    bus_req = '{read: rd, write: !rd, addr: a, wdata: d};
    q = 32'hffff_ffff;
    for (n = 0; n < 8; n++) begin
      @(negedge sys_clk);
      if (bus_ack) begin
        q = bus_rdata;
        break;
      end
    end
    @(negedge sys_clk);
    // released lines toggle so no stale value survives
    bus_req = '{read: 1'b0, write: 1'b0, addr: ~a, wdata: ~d};
  endtask
endmodule

//--- testbench/bctl_board_control_bench.sv
`timescale 1ns/1ps
module bctl_board_control_bench;
  logic                   sys_clk, reset_n, clk_en, clk_locked, bus_error, bus_ack, error_lamp;
  logic [31:0]            bus_rdata, q;
  bctl_pkg::bctl_req_type bus_req;
  bctl_pkg::bctl_ctl_type board_ctl;
  int                     mismatches, check_count;
  bctl_board_control uut (.sys_clk, .reset_n, .clk_en, .bus_req, .bus_ack, .bus_rdata,
    .clk_locked, .bus_error, .error_lamp, .board_ctl);
  bctl_master cpu (.sys_clk, .bus_ack, .bus_rdata, .bus_req);
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    check_count++;
    if (got !== exp) begin
      mismatches++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic give_verdict;
    $display("checks=%0d mismatches=%0d", check_count, mismatches);
    if (mismatches == 0 && check_count > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask
  task automatic wr(input logic [31:0] d);
    cpu.xfer(1'b0, 10'h009, d, q);
    repeat (2) @(negedge sys_clk);
  endtask
  task automatic pulse_err;
    bus_error = 1'b1;
    repeat (6) @(negedge sys_clk);
    bus_error = 1'b0;
    repeat (2) @(negedge sys_clk);
  endtask
  initial begin
    sys_clk = 1'b0;
    forever #4 sys_clk = ~sys_clk;
  end
  initial begin
    repeat (5000) @(posedge sys_clk);
    mismatches++;
    give_verdict();
  end
  initial begin
    {reset_n, clk_locked, bus_error, mismatches, check_count} = '0;
    clk_en = 1'b1;
    repeat (16) @(negedge sys_clk);
    reset_n = 1'b1;
    chk(32'(board_ctl), 32'h0);
    clk_locked = 1'b1;
    repeat (8) @(negedge sys_clk);
    chk(32'(board_ctl.lamp_on), 32'h1);
    pulse_err();
    chk(32'(error_lamp), 32'h1);
    wr(32'h8000_0000);
    chk(32'(error_lamp), 32'h0);
    wr(32'h0);
    chk(32'(board_ctl.lamp_on), 32'h0);
    pulse_err();
    chk(32'(error_lamp), 32'h1);
    wr(32'h1000_00ff);
    chk(32'(board_ctl), {17'h0, 3'b011, 12'h0ff});
    repeat (100) @(negedge sys_clk);
    chk(32'(board_ctl.shutdown_req), 32'h1);
    wr(32'h6fff_f0fe);
    chk(32'(board_ctl), {17'h0, 3'b000, 12'h0fe});
    cpu.xfer(1'b1, 10'h009, 32'h0, q);
    chk(q, 32'h0);
    cpu.xfer(1'b1, 10'h00a, 32'h0, q);
    chk(q, 32'hffff_ffff);
    wr(32'h0000_00ff);
    clk_en = 1'b0;
    cpu.xfer(1'b0, 10'h009, 32'h1000_0000, q);
    clk_en = 1'b1;
    chk(q, 32'hffff_ffff);
    chk(32'(board_ctl), {17'h0, 3'b001, 12'h0ff});
    reset_n = 1'b0;
    @(negedge sys_clk);
    reset_n = 1'b1;
    chk(32'(board_ctl.shutdown_code), 32'h0);
    repeat (8) @(negedge sys_clk);
    chk(32'(board_ctl.lamp_on), 32'h1);
    give_verdict();
  end
endmodule
